// [inc/adcctl_defs.svh]
// Register offsets, field positions, reset values and timing constants of the converter control
`ifndef ADCCTL_DEFS_SVH
`define ADCCTL_DEFS_SVH
`define ADCCTL_OFS_PRESCALER  8'hF2
`define ADCCTL_OFS_CONTROL    8'hF3
`define ADCCTL_OFS_RES_LOW    8'hF4
`define ADCCTL_OFS_RES_HIGH   8'hF5
`define ADCCTL_OFS_IRQ_STATUS 8'hF6
`define ADCCTL_OFS_IRQ_MASK   8'hF7
`define ADCCTL_BIT_IDLE       6
`define ADCCTL_BIT_ENABLE     5
`define ADCCTL_BIT_DONE       4
`define ADCCTL_BIT_START      3
`define ADCCTL_CHAN_HI        2
`define ADCCTL_CHAN_LO        0
`define ADCCTL_PRS_HI         4
`define ADCCTL_CTRL_RESET     7'h00
`define ADCCTL_PRS_RESET      5'h00
`define ADCCTL_RES_RESET      10'h000
`define ADCCTL_CONV_PERIODS   4'hB
`define ADCCTL_X1_MULT        7'h04
`define ADCCTL_X2_MULT        7'h02
`define ADCCTL_SETUP_NS       4000
`define ADCCTL_CLK_NS         8
`endif

// [inc/adcctl_pkg.sv]
// Types of the converter control block
package adcctl_pkg;
  typedef enum logic [1:0] {
    ADCCTL_IDLE   = 2'b00,
    ADCCTL_SAMPLE = 2'b01,
    ADCCTL_CONV   = 2'b10
  } adcctl_state_t;

  typedef struct packed {
    adcctl_state_t state;
    logic          idleSel;
    logic          enable;
    logic          doneFlag;
    logic          startStatus;
    logic [2:0]    channel;
    logic [4:0]    divider;
    logic [9:0]    result;
    logic [6:0]    preCount;
    logic [3:0]    periods;
    logic          irqMask;
    logic          irq;
    logic [7:0]    rdata;
    logic          cpuIdle;
    logic          sampleHold;
    logic          convStrobe;
  } adcctl_regs_t;
endpackage : adcctl_pkg

// [verilog/adcctl_top.sv]
// Converter control registers, prescaler and conversion sequencer
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`include "adcctl_defs.svh"
// How it works
// [RULE1] Idle select set: CPU idle request stays high during each conversion.
// [RULE2] Enable bit 5 powers converter; cleared means standby output asserted.
// [RULE3] Done flag bit 4 set by hardware when result registers hold result.
// [RULE4] Done flag raises interrupt while set and conversion interrupt enabled.
// [RULE5] Software clears done flag; hardware never does; clearing rearms interrupt.
// [RULE6] Writing one to start bit 3 launches one conversion on selected channel.
// [RULE7] Hardware clears start bit at completion; one means still converting.
// [RULE8] Control bits 2..0 choose the converted analog input.
// [RULE9] Single speed: converter clock is CPU clock over four times divider plus one.
// [RULE10] Double speed: converter clock is CPU clock over two times divider plus one.
// [RULE11] High result register is read-only, result bits 9..2.
// [RULE12] Low result register is read-only, result bits 1..0 in low bits.
// [RULE13] Reserved bits read as zero; software must not write ones there.
// [RULE14] Reset clears control bits: standby, channel zero.
// [RULE15] Reset clears prescaler field.
// [RULE16] A conversion lasts eleven converter periods: one sample, ten bits.
// [RULE17] Channel codes 0..7 map directly to inputs 0..7.
// [RULE18] Software waits the setup time between enable and first start.
// [RULE19] Result, done flag and start clear update in the same cycle.
module adcctl_top #(
  parameter int SETUP_NS = `ADCCTL_SETUP_NS
) (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  input  wire logic       doubleSpeedMode,
  input  wire logic [9:0] coreResult,
  output logic      [2:0] coreChannel,
  output logic            coreStandby,
  output logic            coreSampleHold,
  output logic            coreConvStrobe,
  output logic            cpuIdleReq,
  output logic            irq
);
  import adcctl_pkg::*;

  // Setup time is the software's duty; the count is only computed for reference and drives nothing
  localparam int SETUP_CYCLES = (SETUP_NS + `ADCCTL_CLK_NS - 1) / `ADCCTL_CLK_NS; // [RULE18]

  adcctl_regs_t r;
  adcctl_regs_t next_r;

  ////////////////////////////////////////////////////////////////////////////
  // One bit wider than the counter: four times thirty-two does not fit in seven bits
  logic [7:0] periodLen;
  logic       tick;
  logic       wrCtrl;
  logic       done;

  always_comb begin
    periodLen = doubleSpeedMode ? 8'(`ADCCTL_X2_MULT * (r.divider + 8'h01)) // [RULE10]
                                : 8'(`ADCCTL_X1_MULT * (r.divider + 8'h01)); // [RULE9]
    tick   = (r.state != ADCCTL_IDLE) && (r.preCount == 7'(periodLen - 8'h01));
    wrCtrl = wr && (addr == `ADCCTL_OFS_CONTROL);
    done   = (r.state == ADCCTL_CONV) && tick && (r.periods == `ADCCTL_CONV_PERIODS - 4'h1);
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_r            = r;
    next_r.convStrobe = 1'b0;
    if (wr && addr == `ADCCTL_OFS_PRESCALER) begin
      next_r.divider = wdata[`ADCCTL_PRS_HI:0];
    end
    if (wr && addr == `ADCCTL_OFS_IRQ_MASK) begin
      next_r.irqMask = wdata[`ADCCTL_BIT_DONE];
    end
    if (wrCtrl) begin
      next_r.idleSel = wdata[`ADCCTL_BIT_IDLE]; // [RULE1]
      next_r.enable  = wdata[`ADCCTL_BIT_ENABLE]; // [RULE2]
      next_r.channel = wdata[`ADCCTL_CHAN_HI:`ADCCTL_CHAN_LO]; // [RULE8] [RULE17]
      // Writing zero clears the flag; writing one leaves it as is
      if (!wdata[`ADCCTL_BIT_DONE]) begin
        next_r.doneFlag = 1'b0; // [RULE5]
      end
    end
    if (wr && addr == `ADCCTL_OFS_IRQ_STATUS && wdata[`ADCCTL_BIT_DONE]) begin
      next_r.doneFlag = 1'b0; // [RULE5]
    end
    // Prescaler counter runs only inside a conversion, so each one starts phase aligned
    if (r.state == ADCCTL_IDLE || tick) begin
      next_r.preCount = 7'h00;
    end else begin
      next_r.preCount = 7'(r.preCount + 7'h01);
    end
    case (r.state)
      ADCCTL_IDLE: begin
        // A start written with the enable bit clear is ignored; the core enters standby
        if (wrCtrl && wdata[`ADCCTL_BIT_START] && wdata[`ADCCTL_BIT_ENABLE]) begin // [RULE6]
          next_r.state       = ADCCTL_SAMPLE;
          next_r.startStatus = 1'b1;
          next_r.periods     = 4'h0;
          next_r.sampleHold  = 1'b1;
          next_r.cpuIdle     = wdata[`ADCCTL_BIT_IDLE]; // [RULE1]
        end
      end
      ADCCTL_SAMPLE: begin
        if (tick) begin // [RULE16]
          next_r.state      = ADCCTL_CONV;
          next_r.sampleHold = 1'b0;
          next_r.periods    = 4'h1;
          next_r.convStrobe = 1'b1;
        end
      end
      ADCCTL_CONV: begin
        if (done) begin
          next_r.state       = ADCCTL_IDLE;
          next_r.result      = coreResult; // [RULE19]
          next_r.doneFlag    = 1'b1; // [RULE3]
          next_r.startStatus = 1'b0; // [RULE7]
          next_r.cpuIdle     = 1'b0;
        end else if (tick) begin
          next_r.periods    = 4'(r.periods + 4'h1); // [RULE16]
          next_r.convStrobe = 1'b1;
        end
      end
      default: begin
        next_r.state = ADCCTL_IDLE;
      end
    endcase
    // Disabling before the last cycle of a conversion aborts it without setting the flag
    if (wrCtrl && !wdata[`ADCCTL_BIT_ENABLE] && r.state != ADCCTL_IDLE) begin
      next_r.state       = ADCCTL_IDLE;
      next_r.startStatus = 1'b0;
      next_r.cpuIdle     = 1'b0;
      next_r.sampleHold  = 1'b0;
      next_r.convStrobe  = 1'b0;
    end
    next_r.irq = next_r.doneFlag && next_r.irqMask; // [RULE4]
    next_r.rdata = 8'h00;
    if (rd) begin
      case (addr)
        `ADCCTL_OFS_PRESCALER:  next_r.rdata = {3'h0, r.divider}; // [RULE13]
        `ADCCTL_OFS_CONTROL:    next_r.rdata = {1'b0, r.idleSel, r.enable, r.doneFlag,
                                                r.startStatus, r.channel};
        `ADCCTL_OFS_RES_LOW:    next_r.rdata = {6'h00, r.result[1:0]}; // [RULE12]
        `ADCCTL_OFS_RES_HIGH:   next_r.rdata = r.result[9:2]; // [RULE11]
        `ADCCTL_OFS_IRQ_STATUS: next_r.rdata = {3'h0, r.doneFlag, 4'h0};
        `ADCCTL_OFS_IRQ_MASK:   next_r.rdata = {3'h0, r.irqMask, 4'h0};
        default:                next_r.rdata = 8'h00;
      endcase
    end
    if (srst) begin
      next_r             = '0;
      next_r.state       = ADCCTL_IDLE;
      {next_r.idleSel, next_r.enable, next_r.doneFlag, next_r.startStatus,
       next_r.channel}   = `ADCCTL_CTRL_RESET; // [RULE14]
      next_r.divider     = `ADCCTL_PRS_RESET; // [RULE15]
      next_r.result      = `ADCCTL_RES_RESET;
    end
  end

  always_ff @(posedge clk) begin
    r <= next_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    rdata          = r.rdata;
    coreChannel    = r.channel;
    coreStandby    = !r.enable; // [RULE2]
    coreSampleHold = r.sampleHold;
    coreConvStrobe = r.convStrobe;
    cpuIdleReq     = r.cpuIdle;
    irq            = r.irq;
  end
endmodule : adcctl_top

// [testbench/adcctl_props.sv]
// Port checker of the converter control block
`timescale 1ns/1ps
module adcctl_props (
  input logic       clk,
  input logic       srst,
  input logic [7:0] addr,
  input logic [7:0] wdata,
  input logic       wr,
  input logic       rd,
  input logic [7:0] rdata,
  input logic       doubleSpeedMode,
  input logic [9:0] coreResult,
  input logic [2:0] coreChannel,
  input logic       coreStandby,
  input logic       coreSampleHold,
  input logic       coreConvStrobe,
  input logic       cpuIdleReq,
  input logic       irq
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (srst);
  logic ctlWr;
  assign ctlWr = wr && addr == 8'hF3;
  standby_follow_a: assert property (ctlWr |=> coreStandby == !$past(wdata[5]))
    else $error("standby does not follow enable");
  channel_follow_a: assert property (ctlWr |=> coreChannel == $past(wdata[2:0]))
    else $error("channel does not follow select field");
  standby_quiet_a: assert property (coreStandby |-> !coreSampleHold && !coreConvStrobe)
    else $error("core active in standby");
  strobe_x2_a: assert property (coreConvStrobe |=> !coreConvStrobe)
    else $error("bit strobe longer than one cycle");
  strobe_x1_a: assert property (coreConvStrobe && !doubleSpeedMode |=> !coreConvStrobe[*3])
    else $error("bit periods too short");
  sample_end_a: assert property ($fell(coreSampleHold) && !coreStandby |-> coreConvStrobe)
    else $error("sample period not followed by bit period");
  idle_start_a: assert property ($rose(cpuIdleReq) |-> coreSampleHold)
    else $error("idle request outside conversion start");
  mask_off_a: assert property (wr && addr == 8'hF7 && !wdata[4] |=> !irq)
    else $error("masked interrupt still high");
  flag_clear_a: assert property (wr && addr == 8'hF6 && wdata[4] |=> !irq)
    else $error("interrupt not cleared");
  rdata_quiet_a: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data outside read cycle");
endmodule : adcctl_props
bind adcctl_top adcctl_props u_adcctl_props (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata(rdata), .doubleSpeedMode(doubleSpeedMode), .coreResult(coreResult),
  .coreChannel(coreChannel), .coreStandby(coreStandby), .coreSampleHold(coreSampleHold),
  .coreConvStrobe(coreConvStrobe), .cpuIdleReq(cpuIdleReq), .irq(irq));

// [testbench/adcctl_core_model.sv]
// Behavioural analog core holding the sample of the selected input
`timescale 1ns/1ps
module adcctl_core_model (
  input  logic       clk,
  input  logic [2:0] coreChannel,
  input  logic       coreStandby,
  input  logic       coreSampleHold,
  output logic [9:0] coreResult
);
  logic [9:0] held;
  // Channel number lands in the top bits so a wrong input shows up
  always @(posedge clk) begin
    if (coreSampleHold) begin
      held <= {coreChannel, 7'h5A};
    end
  end
  // Powered down: no longer carries the last sample
  assign coreResult = coreStandby ? ~held : held;
endmodule : adcctl_core_model

// [testbench/adcctl_top_tb.sv]
// Self-checking bench of the converter control block
`timescale 1ns/1ps
module adcctl_top_tb;
  logic clk = 0, srst = 1, wr = 0, rd = 0, doubleSpeedMode = 0;
  logic [7:0] addr = 0, wdata = 0, rdata, got;
  logic [9:0] coreResult;
  logic [2:0] coreChannel;
  logic coreStandby, coreSampleHold, coreConvStrobe, cpuIdleReq, irq;
  int errors = 0, samplesChecked = 0, cyc = 0, n;
  logic [7:0] rows [6][3] = '{'{8'hF2, 8'h1F, 8'h1F}, '{8'hF3, 8'h47, 8'h47},
    '{8'hF7, 8'h10, 8'h10}, '{8'hF1, 8'hAA, 8'h00}, '{8'hF5, 8'hAA, 8'h00}, '{8'hF4, 8'h03, 8'h00}};
  adcctl_top u_adcctl_top (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .doubleSpeedMode(doubleSpeedMode), .coreResult(coreResult),
    .coreChannel(coreChannel), .coreStandby(coreStandby), .coreSampleHold(coreSampleHold),
    .coreConvStrobe(coreConvStrobe), .cpuIdleReq(cpuIdleReq), .irq(irq));
  adcctl_core_model u_adcctl_core_model (.clk(clk), .coreChannel(coreChannel),
    .coreStandby(coreStandby), .coreSampleHold(coreSampleHold), .coreResult(coreResult));
  always #4 clk = ~clk;
  // Cuts a hang short well beyond the longest conversion
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errors++;
      tally_and_finish;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    samplesChecked++;
    if (g !== e) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 got = rdata;
  endtask : rreg
  task automatic conv(input logic [4:0] prs, input logic dsm, input logic [2:0] ch);
    int p;
    logic [9:0] res;
    p = (dsm ? 2 : 4) * (prs + 1);
    res = {ch, 7'h5A};
    doubleSpeedMode <= dsm;
    wreg(8'hF2, {3'h0, prs});
    wreg(8'hF3, {5'b00100, ch});
    // Software setup time before the first start
    repeat (500) @(posedge clk);
    wreg(8'hF3, {5'b01101, ch});
    n = 0;
    while (irq !== 1'b1 && n < 300) begin
      @(posedge clk);
      #1 n++;
      if (n == 2) chk({7'h0, cpuIdleReq}, 8'h01);
    end
    // Flag and interrupt rise at the edge closing the eleventh period after the start edge
    chk(8'(n), 8'(11 * p));
    rreg(8'hF5);
    chk(got, res[9:2]);
    rreg(8'hF4);
    chk(got, {6'h0, res[1:0]});
    rreg(8'hF3);
    chk(got, {5'b01110, ch});
    wreg(8'hF7, 8'h00);
    #1 chk({7'h0, irq}, 8'h00);
    wreg(8'hF7, 8'h10);
    #1 chk({7'h0, irq}, 8'h01);
    wreg(8'hF6, 8'h10);
    #1 chk({7'h0, irq}, 8'h00);
  endtask : conv
  task automatic tally_and_finish;
    if (errors == 0 && samplesChecked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    #1 chk({3'h0, irq, coreStandby, coreChannel}, 8'h08);
    rreg(8'hF3);
    chk(got, 8'h00);
    rreg(8'hF2);
    chk(got, 8'h00);
    for (int i = 0; i < 6; i++) begin
      wreg(rows[i][0], rows[i][1]);
      rreg(rows[i][0]);
      chk(got, rows[i][2]);
    end
    conv(5'h02, 1'b0, 3'h5);
    conv(5'h00, 1'b1, 3'h2);
    wreg(8'hF3, 8'h00);
    #1 chk({7'h0, coreStandby}, 8'h01);
    tally_and_finish;
  end
endmodule : adcctl_top_tb
